/* File: pkg/dbg_status_trace_params.svh */
// Offsets, field positions, reset values and counts of the debug status and trace control block
`ifndef DBG_STATUS_TRACE_PARAMS_SVH
`define DBG_STATUS_TRACE_PARAMS_SVH

`define OFS_DEBUG_STATUS          16'h0021
`define OFS_TRACE_CONTROL         16'h0022
`define OFS_COMPARATOR_MATCH_CTRL 16'h0023
`define OFS_DEBUG_CONTROL_PRIMARY 16'h0020
`define OFS_TRACE_LINE_COUNT      16'h0026

`define POS_TRACE_FULL            7
`define POS_TRACE_SOURCE          6
`define POS_TRACE_MODE_LO         2
`define POS_TRIGGER_ALIGN         0
`define POS_ARM                   7
`define POS_IMMEDIATE_TRIGGER_REQUEST                  6

`define RST_DEBUG_STATUS          8'h00
`define RST_TRACE_CONTROL         8'h00
`define RST_COMPARATOR_MATCH_CTRL 8'h00

`define TRACE_DEPTH_LINES         7'h40
`define SSF_DISARMED              3'h0
`define SSF_STATE1                3'h1
`define SSF_FINAL                 3'h4

`endif

/* File: pkg/dbg_status_trace_pkg.sv */
// Types shared by the debug status and trace control block
package dbg_status_trace_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL     = 2'h0,
        MODE_LOOP_SUPPR = 2'h1,
        MODE_DETAIL     = 2'h2,
        MODE_PURE_PC    = 2'h3
    } trace_mode_t;

    typedef enum logic [1:0] {
        PAIR_SINGLE  = 2'h0,
        PAIR_INSIDE  = 2'h1,
        PAIR_OUTSIDE = 2'h2,
        PAIR_RESVD   = 2'h3
    } comparator_pairing_t;

    typedef enum logic [4:0] {
        SEQ_STATE0 = 5'b00001,
        SEQ_STATE1 = 5'b00010,
        SEQ_STATE2 = 5'b00100,
        SEQ_STATE3 = 5'b01000,
        SEQ_FINAL  = 5'b10000
    } seq_state_t;

    typedef struct packed {
        seq_state_t          seq;
        logic [2:0]          sequencer_state_flags;
        logic                trace_full_flag;
        logic [5:0]          line_cnt;
        logic                armed;
        logic                trace_source_enable;
        trace_mode_t         trace_mode_select;
        logic                trigger_align;
        comparator_pairing_t comparator_pairing;
        logic [7:0]          rd_data;
        logic                first_hit_channel;
        logic                second_hit_channel;
        logic                tracing;
        logic                trace_write;
        logic                trace_read_ok;
        logic [1:0]          trace_store_kind;
        logic                session_done;
    } dbg_state_t;

endpackage

/* File: src/dbg_status_trace.sv */
// Debug status, trace control and comparator match control registers with state sequencer
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`include "dbg_status_trace_params.svh"

module dbg_status_trace (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       por_n,
    input  wire logic       clk_en,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       secured,
    input  wire logic       seq_advance,
    input  wire logic [2:0] seq_target,
    input  wire logic       internal_end,
    input  wire logic       break_no_trace,
    input  wire logic       trace_line_stored,
    input  wire logic       trace_read_req,
    input  wire logic       comp_a_hit,
    input  wire logic       comp_b_hit,
    input  wire logic       addr_in_range,
    output logic            armed,
    output logic            tracing,
    output logic            trace_write,
    output logic            trace_read_ok,
    output logic      [1:0] trace_store_kind,
    output logic            first_hit_channel,
    output logic            second_hit_channel,
    output logic            session_done
);

    dbg_status_trace_pkg::dbg_state_t cur;
    dbg_status_trace_pkg::dbg_state_t next_cur;

    logic wr_ctrl;
    logic wr_tcr;
    logic wr_c2;
    logic arm_set;
    logic arm_clr;
    logic immediate_trigger_request_req;
    logic seq_end;
    logic line_push;
    logic suppress;
    logic [2:0] next_flags;

    assign wr_ctrl = reg_wr && (reg_addr == `OFS_DEBUG_CONTROL_PRIMARY);
    assign wr_tcr  = reg_wr && (reg_addr == `OFS_TRACE_CONTROL);
    assign wr_c2   = reg_wr && (reg_addr == `OFS_COMPARATOR_MATCH_CTRL);
    assign arm_set = wr_ctrl && reg_wdata[`POS_ARM];
    assign arm_clr = wr_ctrl && !reg_wdata[`POS_ARM];
    assign immediate_trigger_request_req = wr_ctrl && reg_wdata[`POS_IMMEDIATE_TRIGGER_REQUEST] && cur.armed;

    always_comb begin
        next_cur = cur;
        next_cur.session_done = 1'b0;
        next_cur.trace_write = 1'b0;
        next_flags = cur.sequencer_state_flags;
        seq_end = 1'b0;
        line_push = 1'b0;
        suppress = 1'b0;

        if (cur.armed && seq_advance) begin
            unique case (seq_target)
                3'h1: next_cur.seq = dbg_status_trace_pkg::SEQ_STATE1;
                3'h2: next_cur.seq = dbg_status_trace_pkg::SEQ_STATE2;
                3'h3: next_cur.seq = dbg_status_trace_pkg::SEQ_STATE3;
                `SSF_FINAL: next_cur.seq = dbg_status_trace_pkg::SEQ_FINAL;
                default: next_cur.seq = cur.seq;
            endcase
        end
        if (cur.armed && immediate_trigger_request_req) begin
            next_cur.seq = dbg_status_trace_pkg::SEQ_FINAL;
        end

        unique case (next_cur.seq)
            dbg_status_trace_pkg::SEQ_STATE0: next_flags = `SSF_DISARMED;
            dbg_status_trace_pkg::SEQ_STATE1: next_flags = `SSF_STATE1;
            dbg_status_trace_pkg::SEQ_STATE2: next_flags = 3'h2;
            dbg_status_trace_pkg::SEQ_STATE3: next_flags = 3'h3;
            dbg_status_trace_pkg::SEQ_FINAL:  next_flags = `SSF_FINAL;
            default:                          next_flags = `SSF_DISARMED;
        endcase
        if (cur.armed) begin
            next_cur.sequencer_state_flags = next_flags;
        end

        // Tracing needs source enable and no security
        next_cur.tracing = cur.armed && cur.trace_source_enable && !secured &&
            (cur.trigger_align ? (cur.seq == dbg_status_trace_pkg::SEQ_FINAL)
                               : (cur.seq != dbg_status_trace_pkg::SEQ_STATE0));

        suppress = (cur.trace_mode_select == dbg_status_trace_pkg::MODE_LOOP_SUPPR) &&
                   trace_line_stored && cur.trace_write;
        line_push = cur.tracing && trace_line_stored && !suppress;
        next_cur.trace_write = line_push;
        next_cur.trace_store_kind = cur.trace_mode_select;

        if (line_push) begin
            next_cur.line_cnt = cur.line_cnt + 6'h01;
            if (cur.line_cnt == 6'h3f) begin
                next_cur.trace_full_flag = 1'b1;
            end
        end

        if (cur.tracing && !cur.trigger_align && cur.seq == dbg_status_trace_pkg::SEQ_FINAL) begin
            seq_end = 1'b1;
        end
        if (cur.tracing && cur.trigger_align &&
            (cur.trace_full_flag || (line_push && cur.line_cnt == 6'h3f))) begin
            seq_end = 1'b1;
        end

        // Internal end returns to state 0
        if (cur.armed && (internal_end || seq_end)) begin
            next_cur.seq = dbg_status_trace_pkg::SEQ_STATE0;
            next_cur.sequencer_state_flags = `SSF_DISARMED;
            next_cur.armed = 1'b0;
            next_cur.tracing = 1'b0;
            next_cur.session_done = 1'b1;
        end
        if (cur.armed && break_no_trace && !cur.trace_source_enable) begin
            next_cur.armed = 1'b0;
            next_cur.tracing = 1'b0;
            next_cur.session_done = 1'b1;
        end

        if (arm_clr && cur.armed) begin
            next_cur.armed = 1'b0;
            next_cur.tracing = 1'b0;
            next_cur.seq = dbg_status_trace_pkg::SEQ_STATE0;
            next_cur.sequencer_state_flags = cur.sequencer_state_flags;
        end

        if (arm_set) begin
            next_cur.armed = 1'b1;
            next_cur.seq = dbg_status_trace_pkg::SEQ_STATE1;
            next_cur.sequencer_state_flags = `SSF_STATE1;
            next_cur.trace_full_flag = 1'b0;
            next_cur.line_cnt = 6'h00;
        end

        // Source enable guarded by secure and arm
        if (wr_tcr && !cur.armed && !secured) begin
            next_cur.trace_source_enable = reg_wdata[`POS_TRACE_SOURCE];
        end
        // Mode and align only when disarmed
        if (wr_tcr && !cur.armed) begin
            next_cur.trace_mode_select = dbg_status_trace_pkg::trace_mode_t'(
                reg_wdata[`POS_TRACE_MODE_LO+1:`POS_TRACE_MODE_LO]);
            next_cur.trigger_align = reg_wdata[`POS_TRIGGER_ALIGN];
        end
        if (secured) begin
            next_cur.trace_source_enable = 1'b0;
        end
        if (wr_c2 && !cur.armed) begin
            next_cur.comparator_pairing =
                dbg_status_trace_pkg::comparator_pairing_t'(reg_wdata[1:0]);
        end

        unique case (cur.comparator_pairing)
            dbg_status_trace_pkg::PAIR_SINGLE: begin
                next_cur.first_hit_channel = comp_a_hit;
                next_cur.second_hit_channel = comp_b_hit;
            end
            dbg_status_trace_pkg::PAIR_INSIDE: begin
                next_cur.first_hit_channel = addr_in_range;
                next_cur.second_hit_channel = 1'b0;
            end
            dbg_status_trace_pkg::PAIR_OUTSIDE: begin
                next_cur.first_hit_channel = !addr_in_range;
                next_cur.second_hit_channel = 1'b0;
            end
            dbg_status_trace_pkg::PAIR_RESVD: begin
                next_cur.first_hit_channel = comp_a_hit;
                next_cur.second_hit_channel = 1'b0;
            end
        endcase

        // Trace read only with source set
        next_cur.trace_read_ok = trace_read_req && cur.trace_source_enable &&
                                 !cur.armed && !secured;

        next_cur.rd_data = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `OFS_DEBUG_STATUS:
                    next_cur.rd_data = {cur.trace_full_flag, 4'h0, cur.sequencer_state_flags};
                `OFS_TRACE_CONTROL:
                    next_cur.rd_data = {1'b0, cur.trace_source_enable, 2'b00,
                                        cur.trace_mode_select, 1'b0, cur.trigger_align};
                `OFS_COMPARATOR_MATCH_CTRL:
                    next_cur.rd_data = {6'h00, cur.comparator_pairing};
                `OFS_DEBUG_CONTROL_PRIMARY:
                    next_cur.rd_data = {cur.armed, 7'h00};
                `OFS_TRACE_LINE_COUNT:
                    next_cur.rd_data = {cur.trace_full_flag, 1'b0, cur.line_cnt};
                default:
                    next_cur.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!por_n) begin
            cur <= '0;
            cur.seq <= dbg_status_trace_pkg::SEQ_STATE0;
        end else if (!resetn) begin
            // Other resets keep full and count
            cur.seq <= dbg_status_trace_pkg::SEQ_STATE0;
            cur.sequencer_state_flags <= `SSF_DISARMED;
            cur.armed <= 1'b0;
            cur.tracing <= 1'b0;
            cur.trace_write <= 1'b0;
            cur.trace_read_ok <= 1'b0;
            cur.session_done <= 1'b0;
            cur.rd_data <= 8'h00;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    assign reg_rdata          = cur.rd_data;
    assign armed              = cur.armed;
    assign tracing            = cur.tracing;
    assign trace_write        = cur.trace_write;
    assign trace_read_ok      = cur.trace_read_ok;
    assign trace_store_kind   = cur.trace_store_kind;
    assign first_hit_channel  = cur.first_hit_channel;
    assign second_hit_channel = cur.second_hit_channel;
    assign session_done       = cur.session_done;

endmodule

/* File: testbench/core_model.sv */
// Core-side model: offers trace lines on command
`timescale 1ns/1ns
module core_model (
    input  wire logic       sys_clk,
    input  wire logic       go,
    input  wire logic [7:0] lines,
    input  wire logic       spaced,
    output logic            trace_line_stored,
    output logic            busy
);
    logic [7:0] left = 8'h00;
    initial trace_line_stored = 1'b0;
    initial busy = 1'b0;
    // Spaced offers keep loop suppression out of the count
    always @(posedge sys_clk) begin
        if (go && !busy) begin
            left <= lines;
            busy <= 1'b1;
        end else if (busy) begin
            if (left == 8'h00) begin
                busy <= 1'b0;
                trace_line_stored <= 1'b0;
            end else if (trace_line_stored && spaced) begin
                trace_line_stored <= 1'b0;
            end else begin
                trace_line_stored <= 1'b1;
                left <= left - 8'h01;
            end
        end
    end
endmodule

/* File: testbench/dbg_status_trace_props.sv */
// Port-level assertions of the debug status block
`timescale 1ns/1ns
module dbg_status_trace_props (
    input wire logic sys_clk, resetn, por_n, clk_en, reg_wr, reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    input wire logic secured, internal_end, trace_line_stored, trace_read_req,
    input wire logic armed, tracing, trace_write, trace_read_ok
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn || !por_n);
    rdata_idle_a: assert property (!$past(reg_rd && clk_en) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    status_bits_a: assert property (reg_rd && clk_en && reg_addr == 16'h0021 |=>
        reg_rdata[6:3] == 4'h0 && reg_rdata[2:0] <= 3'h4) else $error("bad status");
    arm_sets_a: assert property (reg_wr && clk_en && reg_addr == 16'h0020
        && reg_wdata[7] |=> armed) else $error("arm not taken");
    end_disarms_a: assert property (armed && internal_end && clk_en && !reg_wr
        |=> !armed) else $error("internal end kept armed");
    secure_trace_a: assert property (secured && $past(secured) |-> !tracing)
        else $error("tracing while secured");
    read_cause_a: assert property (trace_read_ok |-> $past(trace_read_req))
        else $error("read grant without request");
    write_cause_a: assert property (trace_write |-> $past(trace_line_stored))
        else $error("trace write without line");
    reset_idle_a: assert property (@(posedge sys_clk) disable iff (!por_n)
        !resetn |=> !armed && !tracing) else $error("reset left armed");
    cover property (reg_wr && reg_addr == 16'h0020 && reg_wdata[7]);
    cover property (trace_write);
    cover property (trace_read_ok);
endmodule
bind dbg_status_trace dbg_status_trace_props i_dbg_status_trace_props (
    .sys_clk(sys_clk), .resetn(resetn), .por_n(por_n), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .secured(secured), .internal_end(internal_end),
    .trace_line_stored(trace_line_stored), .trace_read_req(trace_read_req),
    .armed(armed), .tracing(tracing), .trace_write(trace_write),
    .trace_read_ok(trace_read_ok));

/* File: testbench/tb_top.sv */
// Self-checking bench of the debug status block
`timescale 1ns/1ns
module tb_top;
    logic sys_clk = 0, resetn = 0, por_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic secured = 0, seq_advance = 0, internal_end = 0, trace_read_req = 0, brk = 0;
    logic comp_a_hit = 0, comp_b_hit = 0, addr_in_range = 0, go = 0, spaced = 0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00, lines = 8'h00, got;
    logic [2:0] seq_target = 3'h0;
    logic [1:0] trace_store_kind;
    logic armed, tracing, trace_write, trace_read_ok, busy, tls;
    logic first_hit_channel, second_hit_channel, session_done;
    logic [7:0] reg_rdata;
    int mismatches = 0, checks = 0, cyc = 0, wcount = 0, rcount = 0, dcount = 0, w0;
    always #2 sys_clk = ~sys_clk;
    dbg_status_trace i_dbg_status_trace (.sys_clk(sys_clk), .resetn(resetn),
        .por_n(por_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .secured(secured),
        .seq_advance(seq_advance), .seq_target(seq_target), .internal_end(internal_end),
        .break_no_trace(brk), .trace_line_stored(tls), .trace_read_req(trace_read_req),
        .comp_a_hit(comp_a_hit), .comp_b_hit(comp_b_hit), .addr_in_range(addr_in_range),
        .armed(armed), .tracing(tracing), .trace_write(trace_write),
        .trace_read_ok(trace_read_ok), .trace_store_kind(trace_store_kind),
        .first_hit_channel(first_hit_channel), .second_hit_channel(second_hit_channel),
        .session_done(session_done));
    core_model i_core_model (.sys_clk(sys_clk), .go(go), .lines(lines),
        .spaced(spaced), .trace_line_stored(tls), .busy(busy));
    always @(posedge sys_clk) begin
        wcount += trace_write;
        rcount += trace_read_ok;
        dcount += session_done;
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_sim;
        end
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        // Sample mid-cycle, away from the edge that launches the data
        @(negedge sys_clk);
        chk($sformatf("reg_%h", a), exp, reg_rdata);
        @(posedge sys_clk);
    endtask
    task automatic pulse(input logic [2:0] which, input logic [2:0] tgt);
        @(posedge sys_clk);
        {seq_advance, internal_end, trace_read_req} <= which;
        seq_target <= tgt;
        @(posedge sys_clk);
        {seq_advance, internal_end, trace_read_req} <= 3'b000;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic feed(input logic [7:0] n, input logic gap);
        @(posedge sys_clk);
        {go, lines, spaced} <= {1'b1, n, gap};
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (400) @(posedge sys_clk) if (!busy) break;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic t_reset;
        rd(16'h0021, 8'h00);
        rd(16'h0022, 8'h00);
        rd(16'h0023, 8'h00);
        wr(16'h0021, 8'hff);
        rd(16'h0021, 8'h00);
    endtask
    task automatic t_config;
        secured <= 1'b1;
        wr(16'h0022, 8'h4d);
        rd(16'h0022, 8'h0d);
        secured <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            wr(16'h0022, 8'h41 | 8'(m << 2));
            rd(16'h0022, 8'h41 | 8'(m << 2));
            chk("store_kind", 8'(m), {6'h00, trace_store_kind});
        end
    endtask
    task automatic t_armed;
        wr(16'h0023, 8'h01);
        wr(16'h0020, 8'h80);
        wr(16'h0022, 8'h00);
        wr(16'h0023, 8'h02);
        rd(16'h0022, 8'h4d);
        rd(16'h0023, 8'h01);
        wr(16'h0020, 8'h00);
    endtask
    task automatic t_seq;
        wr(16'h0020, 8'h80);
        rd(16'h0021, 8'h01);
        for (int s = 2; s < 5; s++) begin
            pulse(3'b100, 3'(s));
            rd(16'h0021, 8'(s));
        end
        wr(16'h0020, 8'h00);
        rd(16'h0021, 8'h04);
        wr(16'h0020, 8'h80);
        w0 = dcount;
        pulse(3'b010, 3'h0);
        rd(16'h0021, 8'h00);
        chk("armed", 8'h00, {7'h00, armed});
        chk("session_done", 8'h01, 8'(dcount - w0));
    endtask
    task automatic t_full;
        wr(16'h0022, 8'h40);
        wr(16'h0020, 8'h80);
        feed(8'd63, 1'b1);
        chk("tracing", 8'h01, {7'h00, tracing});
        rd(16'h0026, 8'h3f);
        feed(8'd1, 1'b1);
        rd(16'h0026, 8'h80);
        rd(16'h0021, 8'h81);
        @(posedge sys_clk) resetn <= 1'b0;
        @(posedge sys_clk) resetn <= 1'b1;
        rd(16'h0021, 8'h80);
        wr(16'h0020, 8'h80);
        rd(16'h0021, 8'h01);
        wr(16'h0020, 8'h00);
    endtask
    // Loop suppression drops the second of two adjacent offers; detail keeps both
    task automatic t_modes;
        for (int k = 1; k < 3; k++) begin
            wr(16'h0022, 8'h40 | 8'(k << 2));
            wr(16'h0020, 8'h80);
            w0 = wcount;
            feed(8'd2, 1'b0);
            chk("writes", 8'(k), 8'(wcount - w0));
            wr(16'h0020, 8'h00);
        end
    endtask
    task automatic t_read;
        for (int s = 0; s < 2; s++) begin
            wr(16'h0022, 8'(s << 6));
            w0 = rcount;
            pulse(3'b001, 3'h0);
            chk("reads", 8'(s), 8'(rcount - w0));
            if (s == 0) begin
                wr(16'h0020, 8'h80);
                brk <= 1'b1;
                @(posedge sys_clk) brk <= 1'b0;
                @(posedge sys_clk);
                chk("armed_brk", 8'h00, {7'h00, armed});
            end
        end
    endtask
    task automatic t_pair;
        logic [15:0] tab;
        tab = 16'h2287;
        for (int p = 0; p < 4; p++) begin
            wr(16'h0023, 8'(p));
            for (int c = 0; c < 2; c++) begin
                {comp_a_hit, comp_b_hit, addr_in_range} <= c ? 3'b011 : 3'b110;
                repeat (2) @(posedge sys_clk);
                chk("hits", 8'(tab[4*p+2*c+:2]), {6'h00, first_hit_channel,
                    second_hit_channel});
            end
        end
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        por_n <= 1'b1;
        t_reset;
        t_config;
        t_armed;
        t_seq;
        t_full;
        t_modes;
        t_read;
        t_pair;
        end_sim;
    end
endmodule
